// file: design/urfe_cfg.svh
// constants for the serial receive block: register map, fields, resets
// assumes a 32-bit ahb-lite bus, one word per register
`ifndef URFE_CFG_SVH
`define URFE_CFG_SVH

`define URFE_OFF_CTRL 8'h00
`define URFE_OFF_STAT 8'h04
`define URFE_OFF_DATA 8'h08
`define URFE_OFF_DIV 8'h0c
`define URFE_OFF_IRQ_STAT 8'h10
`define URFE_OFF_IRQ_MASK 8'h14

`define URFE_CTRL_SERIAL_PORT_ENABLE 0
`define URFE_CTRL_CONTINUOUS_RECEIVE_ENABLE 1
`define URFE_CTRL_RX9 2
`define URFE_CTRL_ADDRESS_DETECT_ENABLE 3

`define URFE_STAT_FRAMING_ERROR_FLAG 0
`define URFE_STAT_OVERRUN_ERROR_FLAG 1
`define URFE_STAT_NINTH 2
`define URFE_STAT_RIF 3
`define URFE_STAT_BUSY 4

`define URFE_IRQ_RX 0
`define URFE_IRQ_OVR 1

`define URFE_CTRL_RST 4'h0
`define URFE_DIV_RST 16'h0010
`define URFE_FIFO_DEPTH 2'h2

`endif

// file: design/urfe_pkg.sv
// types shared by the serial receive block
// no assumptions beyond a systemverilog compiler
package urfe_pkg;

    typedef enum logic [1:0]
    {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } urfe_rx_state_e;

    typedef struct packed
    {
        logic framing_error_flag;
        logic [8:0] data;
    } urfe_entry_s;

    typedef struct packed
    {
        logic address_detect_enable;
        logic rx9;
        logic continuous_receive_enable;
        logic serial_port_enable;
    } urfe_ctrl_s;

endpackage

// file: design/urfe_rx.sv
// serial receive port: two-entry queue, framing/overrun status, 9-bit and
// address-detect modes, ahb-lite register slave with masked interrupt.
// assumes rx_pin is asynchronous; hclk 250 MHz; single word transfers.
//
// What this block does
// - hold at most two characters; a third complete one sets overrun
// - while overrun is set, queued characters stay readable, new ones dropped
// - overrun clears only by dropping continuous receive or port enable
// - each queued character keeps its own stop-bit framing error
// - framing flag follows oldest unread character; a data read advances both
// - framing flag read-only; port disable clears it, receive disable does not
// - framing error alone raises no interrupt and does not stop reception
// - nine-bit mode shifts nine data bits per character
// - ninth bit is msb of oldest character, read before low byte
// - address-detect enable works only with nine-bit reception
// - address mode queues only ninth-bit-set characters, dropping others
// - a disabled receiver releases its pin for general use
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`include "urfe_cfg.svh"

module urfe_rx
    import urfe_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_pin,
    output logic rx_pin_released,
    output logic irq
);

    // bus address phase
    logic ap_wr_q;
    logic [7:0] ap_addr_q;
    logic [31:0] hrdata_q;
    wire ap_take = hsel && hready && htrans[1];
    wire [7:0] ap_off = haddr[7:0];
    wire word_ok = (hsize == 3'h2);
    wire rd_take = ap_take && !hwrite;

    // software registers
    urfe_ctrl_s ctrl_q;
    logic [15:0] div_q;
    logic [1:0] ist_q;
    logic [1:0] imask_q;

    wire wr_ctrl = ap_wr_q && (ap_addr_q == `URFE_OFF_CTRL);
    wire wr_div = ap_wr_q && (ap_addr_q == `URFE_OFF_DIV);
    wire wr_ist = ap_wr_q && (ap_addr_q == `URFE_OFF_IRQ_STAT);
    wire wr_imask = ap_wr_q && (ap_addr_q == `URFE_OFF_IRQ_MASK);

    wire serial_port_enable = ctrl_q.serial_port_enable;
    wire run = ctrl_q.serial_port_enable && ctrl_q.continuous_receive_enable;
    wire addr_mode = ctrl_q.address_detect_enable && ctrl_q.rx9;

    // pin synchroniser
    logic rx_s1_q;
    logic rx_s2_q;

    // receiver
    urfe_rx_state_e state_q;
    logic [15:0] cnt_q;
    logic [3:0] idx_q;
    logic [8:0] shift_q;

    wire tick = (cnt_q == 16'h0000);
    wire [3:0] last_idx = ctrl_q.rx9 ? 4'h8 : 4'h7;
    wire char_done = (state_q == RX_STOP) && tick && run;
    wire [8:0] frame = ctrl_q.rx9 ? shift_q : {1'b0, shift_q[8:1]};
    wire stop_bad = !rx_s2_q;

    // queue
    urfe_entry_s fifo_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic overrun_error_flag_q;

    wire not_empty = (count_q != 2'h0);
    wire pop = rd_take && (ap_off == `URFE_OFF_DATA) && not_empty && serial_port_enable;
    // in address mode anything without the ninth bit is dropped here
    wire accept = char_done && !overrun_error_flag_q && (!addr_mode || frame[8]);
    wire full = (count_q == `URFE_FIFO_DEPTH);
    wire push = accept && (!full || pop);
    wire overrun_set = accept && full && !pop;
    urfe_entry_s head;
    assign head = fifo_q[rd_ptr_q];
    urfe_entry_s new_entry;
    assign new_entry = '{framing_error_flag: stop_bad, data: frame};

    // interrupt events: framing errors deliberately not among them
    wire [1:0] ev = {overrun_set, push};
    wire [1:0] ist_clr = wr_ist ? hwdata[1:0] : 2'h0;

    wire [31:0] stat_val = {27'h0, state_q != RX_IDLE, not_empty,
        head.data[8] && not_empty, overrun_error_flag_q, head.framing_error_flag && not_empty};
    wire [31:0] rd_val =
        (ap_off == `URFE_OFF_CTRL) ? {28'h0, ctrl_q} :
        (ap_off == `URFE_OFF_STAT) ? stat_val :
        (ap_off == `URFE_OFF_DATA) ? {24'h0, head.data[7:0]} :
        (ap_off == `URFE_OFF_DIV) ? {16'h0, div_q} :
        (ap_off == `URFE_OFF_IRQ_STAT) ? {30'h0, ist_q} :
        (ap_off == `URFE_OFF_IRQ_MASK) ? {30'h0, imask_q} : 32'h0;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign irq = |(ist_q & imask_q);
    assign rx_pin_released = !run;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hrdata_q <= 32'h0;
        end
        else
        begin
            ap_wr_q <= ap_take && hwrite && word_ok;
            ap_addr_q <= ap_off;
            if (rd_take)
                hrdata_q <= rd_val;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= `URFE_CTRL_RST;
            div_q <= `URFE_DIV_RST;
            imask_q <= 2'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= hwdata[3:0];
            if (wr_div)
                div_q <= hwdata[15:0];
            if (wr_imask)
                imask_q <= hwdata[1:0];
        end
    end

    // event set wins over a write-one clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ist_q <= 2'h0;
        else
            ist_q <= (ist_q & ~ist_clr) | ev;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= RX_IDLE;
            cnt_q <= 16'h0;
            idx_q <= 4'h0;
            shift_q <= 9'h0;
        end
        else if (!run)
            state_q <= RX_IDLE;
        else
        begin
            cnt_q <= tick ? div_q - 16'h1 : cnt_q - 16'h1;
            case (state_q)
                RX_IDLE:
                begin
                    cnt_q <= {1'b0, div_q[15:1]};
                    if (!rx_s2_q)
                        state_q <= RX_START;
                end
                RX_START:
                begin
                    idx_q <= 4'h0;
                    // a glitch shorter than half a bit is not a start
                    if (tick)
                        state_q <= rx_s2_q ? RX_IDLE : RX_DATA;
                end
                RX_DATA:
                begin
                    if (tick)
                    begin
                        shift_q <= {rx_s2_q, shift_q[8:1]};
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == last_idx)
                            state_q <= RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    // framing error does not hold the receiver
                    if (tick)
                        state_q <= RX_IDLE;
                end
                default:
                    state_q <= RX_IDLE;
            endcase
        end
    end

    // queue entries; port disable empties the queue
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_entry
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    fifo_q[gi] <= '0;
                else if (!serial_port_enable)
                    fifo_q[gi] <= '0;
                else if (push && (wr_ptr_q == 1'(gi)))
                    fifo_q[gi] <= new_entry;
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end
        else if (!serial_port_enable)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= !wr_ptr_q;
            if (pop)
                rd_ptr_q <= !rd_ptr_q;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            overrun_error_flag_q <= 1'b0;
        else if (!run)
            overrun_error_flag_q <= 1'b0;
        else if (overrun_set)
            overrun_error_flag_q <= 1'b1;
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_full_char;
        accept && full && !pop;
    endsequence

    sequence s_overrun_held;
        overrun_error_flag_q && run;
    endsequence

    // a write to control in the same cycle may empty the queue instead
    sequence s_pop_in_overrun;
        overrun_error_flag_q && pop && !wr_ctrl;
    endsequence

    sequence s_rx_paused;
        serial_port_enable && !ctrl_q.continuous_receive_enable && !pop && !wr_ctrl;
    endsequence

    sequence s_addr_char;
        char_done && addr_mode && frame[8] && !overrun_error_flag_q && !full && !pop;
    endsequence

    sequence s_bad_stop_char;
        push && new_entry.framing_error_flag && !ist_q[1];
    endsequence

    a_queue_depth_max: assert property (count_q <= 2'h2)
        else $error("queue holds more than two characters");

    a_overrun_on_third: assert property (s_full_char |=> overrun_error_flag_q && count_q == 2'h2)
        else $error("third character did not raise overrun");

    a_overrun_blocks_push: assert property (s_overrun_held |-> !push)
        else $error("character queued while overrun set");

    a_overrun_clear_cause: assert property ($fell(overrun_error_flag_q) |-> !$past(run))
        else $error("overrun cleared without receive or port disable");

    a_framing_error_flag_tracks_head: assert property (not_empty |-> stat_val[0] == head.framing_error_flag)
        else $error("framing flag not tied to oldest character");

    a_pop_advances: assert property (pop && !push |=> count_q == $past(count_q) - 2'h1)
        else $error("data read did not advance queue");

    a_framing_error_flag_port_off: assert property (!serial_port_enable |=> stat_val[0] == 1'b0 && count_q == 2'h0)
        else $error("port disable left framing flag or queue");

    a_framing_error_flag_no_event: assert property (s_bad_stop_char |=> !ist_q[1] && state_q == RX_IDLE)
        else $error("framing error drove an interrupt event");

    a_eight_bit_clear: assert property (push && !ctrl_q.rx9 |-> !new_entry.data[8])
        else $error("eight-bit character carries ninth bit");

    a_addr_filter: assert property (char_done && addr_mode && !frame[8] |-> !push)
        else $error("non-address character queued in address mode");

    a_rif_level: assert property (push && count_q == 2'h0 |=> stat_val[3] [*1] ##0 not_empty)
        else $error("receive flag not set with unread character");

    a_release_idle: assert property (!run |-> rx_pin_released ##1 state_q == RX_IDLE)
        else $error("disabled receiver still holds its pin");

    a_overrun_stays: assert property (overrun_error_flag_q && run |=> overrun_error_flag_q)
        else $error("overrun cleared while receiving");

    a_overrun_read: assert property (s_pop_in_overrun |=> count_q == $past(count_q) - 2'h1)
        else $error("queued character not readable during overrun");

    a_continuous_receive_enable_keeps_framing_error_flag: assert property (s_rx_paused |=> head.framing_error_flag == $past(head.framing_error_flag))
        else $error("receive disable changed framing flag");

    a_addr_queued: assert property (s_addr_char |=> count_q == $past(count_q) + 2'h1)
        else $error("address character not queued");

    a_rif_empty: assert property (!not_empty |-> !stat_val[3] && !stat_val[0])
        else $error("receive or framing flag set with empty queue");

endmodule

// file: verification/urfe_tx_model.sv
// serial transmitter model on the receive line, lsb first, idle high
// assumes clocks per bit equal the receiver's divider setting
`timescale 1ns/100ps
module urfe_tx_model
(
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    task automatic send(input logic [8:0] v, input int nb, input int div, input bit bad);
        for (int i = 0; i < nb + 2; i++)
        begin
            @(posedge clk);
            line <= (i == 0) ? 1'b0 : (i > nb) ? !bad : v[i-1];
            repeat (div - 1) @(posedge clk);
        end
        @(posedge clk);
        line <= 1'b1;
        // idle gap so a low stop bit cannot pose as a start
        repeat (2 * div) @(posedge clk);
    endtask
endmodule

// file: verification/tb_top.sv
// bench: ahb-lite master, queue reference model, serial line driver
// assumes the slave answers okay, waits bounded by the cycle limit
`timescale 1ns/100ps
`include "urfe_cfg.svh"
module tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic hreadyout, hresp, rx_pin, rel, irq;
    int num_errors = 0, comparisons = 0, cyc = 0, ctl = 0, ist = 0, q[$];
    bit ovr = 0;
    urfe_rx uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_pin(rx_pin), .rx_pin_released(rel), .irq(irq));
    urfe_tx_model tx (.clk(hclk), .line(rx_pin));
    initial forever #2 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rg(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk("register", e, rd);
        chk("response", 32'h0, {31'h0, hresp});
    endtask
    task automatic ctrl(input int v);
        ahb(1'b1, `URFE_OFF_CTRL, v);
        ctl = v;
        if (!v[1] || !v[0])
            ovr = 0;
        if (!v[0])
            q.delete();
        // new enables show only once the write edge has settled
        @(negedge hclk);
        chk("released", !(v[0] && v[1]), rel);
        @(posedge hclk);
    endtask
    task automatic send(input int v, input bit bad);
        tx.send(v[8:0], ctl[2] ? 9 : 8, 8, bad);
        v = v & (ctl[2] ? 'h1ff : 'hff);
        // address filter only counts with nine-bit reception on
        if ((ctl & 3) == 3 && !(ctl[3] && ctl[2] && !v[8]) && !ovr)
        begin
            if (q.size() < 2)
            begin
                q.push_back(v | (bad << 9));
                ist |= 1;
            end
            else
            begin
                ovr = 1;
                ist |= 2;
            end
        end
    endtask
    task automatic pop();
        // bit3 is the receive flag: the queue is never empty here
        rg(`URFE_OFF_STAT, {1'b1, q[0][8], ovr, q[0][9]});
        rg(`URFE_OFF_DATA, q[0][7:0]);
        void'(q.pop_front());
    endtask
    initial
    begin
        void'($urandom(5));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk("released", 1, rel);
        rg(`URFE_OFF_CTRL, 0);
        rg(`URFE_OFF_DIV, 'h10);
        rg(8'h1c, 0);
        ahb(1'b1, `URFE_OFF_DIV, 8);
        ahb(1'b1, `URFE_OFF_IRQ_MASK, 3);
        ctrl(3);
        for (int i = 0; i < 4; i++)
            send($urandom % 256, i == 1);
        chk("irq", 1, irq);
        pop();
        ctrl(1);
        pop();
        rg(`URFE_OFF_STAT, 0);
        ahb(1'b1, `URFE_OFF_IRQ_STAT, 3);
        @(posedge hclk);
        chk("irq", 0, irq);
        ist = 0;
        ctrl(7);
        send($urandom % 256 | 'h100, 1);
        send($urandom % 512, 0);
        rg(`URFE_OFF_IRQ_STAT, ist);
        pop();
        pop();
        send('h0f5, 1);
        ctrl(0);
        rg(`URFE_OFF_STAT, 0);
        ctrl(11);
        send('h55, 0);
        pop();
        ctrl(15);
        send('h055, 0);
        send('h1aa, 0);
        pop();
        ctrl(7);
        send('h033, 0);
        pop();
        stop_test();
    end
endmodule
